// ===== rtl/rxo_pkg.sv
// Function
// R1: dual-rail drives negative pulses on neg rail
// R2: single-rail: neg rail pulses on violations only
// R3: framer samples violation flag on recovered clock
// R4: hardware mode: select pin high means single-rail
// R5: host mode: control register bit picks format
// R6: hardware mode: monitor pin high enters monitoring
// R7: host mode: register bits; pin is serial out
// R8: without single-frequency, reference matches line rate
// R9: single-frequency input selects 12.288 MHz reference
// R10: single-frequency mode outputs line-rate clock
// R11: single-rail enables codec, dual-rail bypasses
// R12: control style high is host, low hardware
// R13: violation pulse lasts one clock, aligned
package rxo_pkg;
  // ****************************************************************
  // line modes and reference rates
  // ****************************************************************
  typedef enum logic [1:0] {RXO_E3, RXO_DS3, RXO_STS1} rxo_line_t;
  localparam int RXO_REF_E3_KHZ    = 34368;
  localparam int RXO_REF_DS3_KHZ   = 44736;
  localparam int RXO_REF_STS1_KHZ  = 51840;
  localparam int RXO_REF_SFM_KHZ   = 12288;
  // clock output divide ratios per line mode (half periods)
  localparam logic [3:0] RXO_DIV_E3   = 4'h3;
  localparam logic [3:0] RXO_DIV_DS3  = 4'h2;
  localparam logic [3:0] RXO_DIV_STS1 = 4'h1;
  // ****************************************************************
  // host-mode register bits held inside the device end
  // ****************************************************************
  localparam int RXO_BCR_SINGLE_RAIL = 0;
  localparam int RXO_RCR_MONITOR     = 1;
  localparam logic [1:0] RXO_CTRL_RESET = 2'h0;
  // ****************************************************************
  // APB map of the framer end
  // ****************************************************************
  localparam logic [7:0] RXO_A_CTRL   = 8'h00;
  localparam logic [7:0] RXO_A_STATUS = 8'h04;
  localparam logic [7:0] RXO_A_VCOUNT = 8'h08;
  localparam logic [7:0] RXO_A_PCOUNT = 8'h0c;
  localparam int RXO_C_HOST   = 0;
  localparam int RXO_C_SRAIL  = 1;
  localparam int RXO_C_MON    = 2;
  localparam int RXO_C_SFM    = 3;
  localparam int RXO_C_LINE   = 4;
  localparam int RXO_C_LINE_W = 2;
  localparam logic [31:0] RXO_ERR_DATA = 32'hdeadbeef;
endpackage

// ===== rtl/rxo_if.sv
`timescale 1ns/10ps
interface rxo_if;
  logic pos_rail_out;             // positive pulse / single-rail data
  logic neg_rail_or_violation_out;// negative pulse or violation
  logic recovered_rx_clock;       // recovered clock level
  logic clk_out;                  // synthesized low-jitter clock
  logic sdo;                      // serial data out (host mode)
  logic control_style_select;     // 1 host, 0 hardware
  logic rail_format_select;       // 1 single-rail, 0 dual-rail
  logic monitor_mode_select;      // monitor enable pin
  logic single_freq_enable;       // single-frequency mode
  logic [1:0] line_mode;          // rxo_line_t encoding
  logic reg_we;                   // host register write strobe
  logic [1:0] reg_wdata;          // {monitor, single_rail}
  modport dev (
    output pos_rail_out, neg_rail_or_violation_out,
           recovered_rx_clock, clk_out, sdo,
    input  control_style_select, rail_format_select,
           monitor_mode_select, single_freq_enable, line_mode,
           reg_we, reg_wdata
  );
  modport frm (
    input  pos_rail_out, neg_rail_or_violation_out,
           recovered_rx_clock, clk_out, sdo,
    output control_style_select, rail_format_select,
           monitor_mode_select, single_freq_enable, line_mode,
           reg_we, reg_wdata
  );
endinterface

// ===== rtl/rxo_clkdiv.sv
`timescale 1ns/10ps
module rxo_clkdiv
  import rxo_pkg::*;
(
  input  wire logic       clk_sys,  // system clock
  input  wire logic       reset,    // sync reset
  input  wire logic       enable,   // run divider
  input  wire logic [3:0] half,     // half period in cycles
  output logic            clk_o     // divided clock
);
  typedef struct packed {
    logic [3:0] cnt;
    logic       clk;
  } rxo_div_t;
  rxo_div_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (!enable) begin
      s_nxt = '0;
    end else if (s_r.cnt + 4'h1 >= half) begin
      s_nxt.cnt = '0;
      s_nxt.clk = ~s_r.clk;
    end else begin
      s_nxt.cnt = s_r.cnt + 4'h1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign clk_o = s_r.clk;
endmodule

// ===== rtl/rxo_dev.sv
`timescale 1ns/10ps
module rxo_dev
  import rxo_pkg::*;
(
  input  wire logic clk_sys,    // system clock
  input  wire logic reset,      // sync reset, active high
  input  wire logic line_pos,   // decoded positive line pulse
  input  wire logic line_neg,   // decoded negative line pulse
  input  wire logic line_viol,  // violation seen by decoder
  output logic      codec_en,   // line-code codec enabled
  output logic      monitor_on, // receiver in monitoring mode
  rxo_if.dev        lnk         // link to framer
);
  typedef struct packed {
    logic [1:0] ctrl;
    logic       pos;
    logic       neg;
    logic       rclk;
    logic       ck;
    logic       codec;
    logic       mon;
    logic       sdo;
  } rxo_dev_t;
  rxo_dev_t s_r, s_nxt;
  logic srail, div_clk;
  logic [3:0] half;
  always_comb begin
    case (rxo_line_t'(lnk.line_mode))
      RXO_E3:   half = RXO_DIV_E3;
      RXO_DS3:  half = RXO_DIV_DS3;
      default:  half = RXO_DIV_STS1;
    endcase
  end
  rxo_clkdiv u_div (
    .clk_sys (clk_sys),
    .reset   (reset),
    .enable  (lnk.single_freq_enable), // R9
    .half    (half),
    .clk_o   (div_clk)
  );
  // ****************************************************************
  // mode and output selection
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    if (lnk.control_style_select && lnk.reg_we)
      s_nxt.ctrl = lnk.reg_wdata; // R5 R7
    srail = lnk.control_style_select ? // R12
            s_r.ctrl[RXO_BCR_SINGLE_RAIL] : lnk.rail_format_select; // R4
    s_nxt.mon = lnk.control_style_select ?
                s_r.ctrl[RXO_RCR_MONITOR] : lnk.monitor_mode_select; // R6
    s_nxt.codec = srail; // R11
    s_nxt.rclk = ~s_r.rclk;
    if (!s_r.rclk) begin
      // data move with the rising edge of the recovered clock
      s_nxt.pos = srail ? (line_pos | line_neg) : line_pos;
      s_nxt.neg = srail ? line_viol : line_neg; // R1 R2 R13
    end
    s_nxt.ck = lnk.single_freq_enable & div_clk; // R10
    s_nxt.sdo = lnk.control_style_select & s_r.mon; // R7
  end
  always_ff @(posedge clk_sys) begin
    if (reset) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign lnk.pos_rail_out = s_r.pos;
  assign lnk.neg_rail_or_violation_out = s_r.neg;
  assign lnk.recovered_rx_clock = s_r.rclk;
  assign lnk.clk_out = s_r.ck;
  assign lnk.sdo = s_r.sdo;
  assign codec_en = s_r.codec;
  assign monitor_on = s_r.mon;
endmodule

// ===== rtl/rxo_frm.sv
`timescale 1ns/10ps
module rxo_frm
  import rxo_pkg::*;
(
  input  wire logic        clk_sys, // system clock
  input  wire logic        reset,   // sync reset
  input  wire logic        psel,    // apb select
  input  wire logic        penable, // apb enable
  input  wire logic        pwrite,  // apb direction
  input  wire logic [7:0]  paddr,   // apb address
  input  wire logic [31:0] pwdata,  // apb write data
  output logic [31:0]      prdata,  // apb read data
  output logic             pready,  // apb ready
  output logic             pslverr, // apb error
  rxo_if.frm               lnk      // link to device
);
  typedef struct packed {
    logic [5:0]  ctrl;
    logic        we;
    logic [1:0]  wd;
    logic        rck;
    logic [15:0] vcnt;
    logic [15:0] pcnt;
    logic [31:0] rd;
    logic        rdy;
    logic        err;
  } rxo_frm_t;
  rxo_frm_t s_r, s_nxt;
  logic acc, rise;
  always_comb begin
    s_nxt = s_r;
    acc = psel && penable && !s_r.rdy;
    s_nxt.rdy = acc;
    s_nxt.err = 1'b0;
    s_nxt.we = 1'b0;
    s_nxt.rck = lnk.recovered_rx_clock;
    rise = lnk.recovered_rx_clock && !s_r.rck;
    if (rise) begin
      // R3 sample on the recovered clock edge
      if (lnk.neg_rail_or_violation_out && s_r.ctrl[RXO_C_SRAIL])
        s_nxt.vcnt = s_r.vcnt + 16'h1;
      if (lnk.pos_rail_out)
        s_nxt.pcnt = s_r.pcnt + 16'h1;
    end
    if (acc) begin
      s_nxt.rd = '0;
      case (paddr)
        RXO_A_CTRL: begin
          if (pwrite) begin
            s_nxt.ctrl = pwdata[5:0];
            s_nxt.we = 1'b1;
            s_nxt.wd = {pwdata[RXO_C_MON], pwdata[RXO_C_SRAIL]};
          end
          s_nxt.rd[5:0] = s_r.ctrl;
        end
        RXO_A_STATUS: s_nxt.rd[0] = lnk.sdo;
        RXO_A_VCOUNT: begin
          if (pwrite) s_nxt.vcnt = '0;
          s_nxt.rd[15:0] = s_r.vcnt;
        end
        RXO_A_PCOUNT: begin
          if (pwrite) s_nxt.pcnt = '0;
          s_nxt.rd[15:0] = s_r.pcnt;
        end
        default: begin
          s_nxt.rd = RXO_ERR_DATA;
          s_nxt.err = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (reset) s_r <= '0;
    else s_r <= s_nxt;
  end
  assign prdata = s_r.rd;
  assign pready = s_r.rdy;
  assign pslverr = s_r.err;
  assign lnk.control_style_select = s_r.ctrl[RXO_C_HOST]; // R12
  assign lnk.rail_format_select = s_r.ctrl[RXO_C_SRAIL]; // R4
  assign lnk.monitor_mode_select = s_r.ctrl[RXO_C_MON]; // R6
  assign lnk.single_freq_enable = s_r.ctrl[RXO_C_SFM]; // R8 R9
  assign lnk.line_mode = s_r.ctrl[RXO_C_LINE +: RXO_C_LINE_W];
  assign lnk.reg_we = s_r.we; // R5 R7
  assign lnk.reg_wdata = s_r.wd;
endmodule

// ===== dv/rxo_checker.sv
`timescale 1ns/10ps
// ****************************************************************
// link checks
// ****************************************************************
module rxo_checker
  import rxo_pkg::*;
(
  input wire logic       clk_sys,                   // clock
  input wire logic       reset,                     // sync reset
  input wire logic       pos_rail_out,              // pos data
  input wire logic       neg_rail_or_violation_out, // neg or viol
  input wire logic       recovered_rx_clock,        // rx clock
  input wire logic       clk_out,                   // synth clock
  input wire logic       sdo,                       // serial out
  input wire logic       control_style_select,      // host select
  input wire logic       single_freq_enable,        // sfm select
  input wire logic [1:0] line_mode,                 // line mode
  input wire logic       reg_we                     // host write
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence s_flip;
    $changed(clk_out);
  endsequence
  a_rx_clock_toggle: assert property (
    !recovered_rx_clock |=> recovered_rx_clock ##1 !recovered_rx_clock)
    else $error("rx clock not toggling");
  a_neg_aligned: assert property (
    $changed(neg_rail_or_violation_out) |-> $rose(recovered_rx_clock))
    else $error("neg rail moved off clock rise");
  a_pos_aligned: assert property (
    !$rose(recovered_rx_clock) |-> $stable(pos_rail_out))
    else $error("pos rail moved off clock rise");
  a_sdo_hw_quiet: assert property (
    !control_style_select [*3] |-> !sdo)
    else $error("serial out active in hardware mode");
  a_clk_out_off: assert property (
    !single_freq_enable [*4] |-> !clk_out)
    else $error("clock out runs without sfm");
  a_clk_out_sts1: assert property (
    (single_freq_enable && line_mode == 2'h2) [*4] ##0 s_flip |=> s_flip)
    else $error("sts1 clock out half period wrong");
  a_clk_out_e3: assert property (
    (single_freq_enable && line_mode == 2'h0) [*6] ##0 s_flip
    |=> $stable(clk_out) [*2] ##1 s_flip)
    else $error("e3 clock out half period wrong");
  a_reg_we_pulse: assert property (
    reg_we |=> !reg_we)
    else $error("register write strobe too long");
endmodule

// ===== dv/tb_rx_output_and_clock_mode_select.sv
`timescale 1ns/10ps
// ****************************************************************
// bench
// ****************************************************************
module tb_rx_output_and_clock_mode_select;
  import rxo_pkg::*;
  logic        clk_sys, reset, psel, penable, pwrite, err;
  logic        line_pos, line_neg, line_viol, pready, pslverr;
  logic        codec_en, monitor_on;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  int          fail_count, checks;
  int          cyc = 0;
  rxo_if lnk();
  rxo_dev rxo_dev_i(.clk_sys(clk_sys), .reset(reset), .line_pos(line_pos),
    .line_neg(line_neg), .line_viol(line_viol), .codec_en(codec_en),
    .monitor_on(monitor_on), .lnk(lnk.dev));
  rxo_frm rxo_frm_i(.clk_sys(clk_sys), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk.frm));
  rxo_checker rxo_checker_i(.clk_sys(clk_sys), .reset(reset),
    .pos_rail_out(lnk.pos_rail_out), .sdo(lnk.sdo), .reg_we(lnk.reg_we),
    .neg_rail_or_violation_out(lnk.neg_rail_or_violation_out),
    .recovered_rx_clock(lnk.recovered_rx_clock), .clk_out(lnk.clk_out),
    .control_style_select(lnk.control_style_select),
    .single_freq_enable(lnk.single_freq_enable), .line_mode(lnk.line_mode));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic conclude();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic ctl(input logic [31:0] d);
    apb(1'b1, RXO_A_CTRL, d);
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic ln(input logic p, n, v, ep, en);
    logic sp = 1'b0;
    logic sn = 1'b0;
    @(posedge clk_sys);
    line_pos <= p;
    line_neg <= n;
    line_viol <= v;
    repeat (2) @(posedge clk_sys);
    line_pos <= 1'b0;
    line_neg <= 1'b0;
    line_viol <= 1'b0;
    repeat (6) begin
      // look between edges, where the rails are settled
      @(negedge clk_sys);
      sp |= lnk.pos_rail_out;
      sn |= lnk.neg_rail_or_violation_out;
    end
    chk("pos rail", ep, sp);
    chk("neg rail", en, sn);
  endtask
  task automatic t_regs();
    apb(1'b0, RXO_A_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    chk("unmapped data", RXO_ERR_DATA, rd);
  endtask
  task automatic t_rails();
    ctl(32'h0);
    chk("codec dual", 32'h0, codec_en);
    ln(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    ln(1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
    ctl(32'h2);
    chk("codec single", 32'h1, codec_en);
    ln(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    ln(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
  endtask
  task automatic t_counts();
    apb(1'b0, RXO_A_VCOUNT, 32'h0);
    chk("viol count", 32'h1, rd);
    apb(1'b0, RXO_A_PCOUNT, 32'h0);
    chk("pos count", 32'h2, rd);
    apb(1'b1, RXO_A_VCOUNT, 32'h0);
    apb(1'b0, RXO_A_VCOUNT, 32'h0);
    chk("viol cleared", 32'h0, rd);
    apb(1'b1, RXO_A_PCOUNT, 32'h0);
    apb(1'b0, RXO_A_PCOUNT, 32'h0);
    chk("pos cleared", 32'h0, rd);
  endtask
  task automatic t_host();
    ctl(32'h3);
    chk("host single", 32'h1, codec_en);
    ctl(32'h1);
    chk("host dual", 32'h0, codec_en);
    ctl(32'h5);
    chk("host monitor", 32'h1, monitor_on);
    apb(1'b0, RXO_A_STATUS, 32'h0);
    chk("serial out", 32'h1, rd & 32'h1);
    ctl(32'h4);
    chk("hw monitor", 32'h1, monitor_on);
    apb(1'b0, RXO_A_STATUS, 32'h0);
    chk("hw serial out", 32'h0, rd & 32'h1);
  endtask
  task automatic t_sfm();
    logic [3:0] hv [3] = '{RXO_DIV_E3, RXO_DIV_DS3, RXO_DIV_STS1};
    logic v;
    int n;
    for (int m = 0; m < 3; m++) begin
      ctl(32'h8 | (m << RXO_C_LINE));
      v = lnk.clk_out;
      while (lnk.clk_out === v) @(posedge clk_sys);
      v = lnk.clk_out;
      n = 0;
      do begin
        @(posedge clk_sys);
        n++;
      end while (lnk.clk_out === v && n < 20);
      chk("half period", hv[m], n);
    end
    ctl(32'h0);
    chk("clock out off", 32'h0, lnk.clk_out);
  endtask
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = {4'h8, 40'h0};
    {line_pos, line_neg, line_viol} = 3'h0;
    fail_count = 0;
    checks = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    t_regs();
    t_rails();
    t_counts();
    t_host();
    t_sfm();
    conclude();
  end
endmodule
